// >>> shared/mdp_pkg.sv
package mdp_pkg;
	localparam int DQ_W = 16;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 14;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int ROW_W = 13;
	localparam int COLS_X16 = 1024;
	localparam int COLS_X32 = 512;
	localparam int PRECHARGE_SCOPE_BIT = 10;
	localparam int BL_LSB = 0;
	localparam int CL_LSB = 4;
	localparam logic [ADDR_W-1:0] MODE_RST = 14'h0033;
	localparam logic [ADDR_W-1:0] EXT_RST = 14'h0000;
	localparam logic [BANK_W-1:0] MR_BASE = 2'h0;
	localparam logic [BANK_W-1:0] MR_EXT = 2'h2;
	localparam int REF_PERIOD_NS = 20;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * REF_PERIOD_NS);
	localparam int LINK_MID_CYC = LINK_HALF_CYC / 2;

	// Codes are {row, column, write} strobe levels with select low
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_AREF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WRITE = 3'h4,
		CMD_READ = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} mdp_cmd_t;

	typedef enum logic [1:0] {
		PW_RUN = 2'h0,
		PW_PDN = 2'h1,
		PW_SREF = 2'h3
	} mdp_pwr_t;

	typedef enum logic [1:0] {
		BS_IDLE = 2'h0,
		BS_LAT = 2'h1,
		BS_RD = 2'h3,
		BS_WR = 2'h2
	} mdp_bst_t;

	// Burst length code to transfer count
	function automatic logic [4:0] mdp_bl_len(input logic [2:0] code);
		unique case (code)
			3'h1: mdp_bl_len = 5'h02;
			3'h2: mdp_bl_len = 5'h04;
			3'h3: mdp_bl_len = 5'h08;
			3'h4: mdp_bl_len = 5'h10;
			default: mdp_bl_len = 5'h02;
		endcase
	endfunction
endpackage

// >>> shared/mdp_link_if.sv
`timescale 1ns/1ns
interface mdp_link_if #(parameter int DQ_W = mdp_pkg::DQ_W);
	localparam int LN = DQ_W / 8;
	logic diff_clock_true;
	logic diff_clock_comp;
	logic clock_gate;
	logic chip_sel_n;
	logic row_strobe_n;
	logic col_strobe_n;
	logic wr_strobe_n;
	logic [mdp_pkg::BANK_W-1:0] bank_select_bits;
	logic [mdp_pkg::ADDR_W-1:0] address_lines;
	logic [LN-1:0] byte_mask_lanes;
	logic [DQ_W-1:0] host_data_o;
	logic host_data_oe;
	logic [LN-1:0] host_strobe_o;
	logic host_strobe_oe;
	logic [DQ_W-1:0] dev_data_o;
	logic dev_data_oe;
	logic [LN-1:0] dev_strobe_o;
	logic dev_strobe_oe;
	logic [DQ_W-1:0] data_lines;
	logic [LN-1:0] strobe_lanes;

	// Shared wires follow the device when it enables, else the host
	assign data_lines = dev_data_oe ? dev_data_o : host_data_o;
	assign strobe_lanes = dev_strobe_oe ? dev_strobe_o : host_strobe_o;

	modport dev (
		input diff_clock_true, diff_clock_comp, clock_gate, chip_sel_n, row_strobe_n,
		input col_strobe_n, wr_strobe_n, bank_select_bits, address_lines, byte_mask_lanes,
		input data_lines, strobe_lanes,
		output dev_data_o, dev_data_oe, dev_strobe_o, dev_strobe_oe
	);
	modport host (
		output diff_clock_true, diff_clock_comp, clock_gate, chip_sel_n, row_strobe_n,
		output col_strobe_n, wr_strobe_n, bank_select_bits, address_lines, byte_mask_lanes,
		output host_data_o, host_data_oe, host_strobe_o, host_strobe_oe,
		input data_lines, strobe_lanes
	);
endinterface

// >>> design/mdp_dev.sv
`timescale 1ns/1ns
module mdp_dev #(
	parameter int DQ_W = mdp_pkg::DQ_W,
	parameter int MEM_RB = 2,
	parameter int MEM_CB = 4
) (
	input wire logic ref_clk,
	input wire logic srst,
	mdp_link_if.dev lnk,
	output mdp_pkg::mdp_pwr_t pwr_state,
	output logic [mdp_pkg::NBANK-1:0] open_banks,
	output logic [mdp_pkg::ADDR_W-1:0] base_mode,
	output logic [mdp_pkg::ADDR_W-1:0] ext_mode
);
	import mdp_pkg::*;
	localparam int LN = DQ_W / BYTE_W;
	localparam int COL_W = $clog2(DQ_W == 16 ? COLS_X16 : COLS_X32);
	localparam int MEM_AW = BANK_W + MEM_RB + MEM_CB;
	localparam int SW = 7 + BANK_W + ADDR_W + 2 * LN + DQ_W;

	// --------------------------------
	// Input synchronisers
	// --------------------------------
	logic [SW-1:0] s1_ff;
	logic [SW-1:0] s2_ff;
	logic true_d_ff;
	logic [LN-1:0] stb_d_ff;
	wire [SW-1:0] raw = {lnk.diff_clock_true, lnk.diff_clock_comp, lnk.clock_gate,
		lnk.chip_sel_n, lnk.row_strobe_n, lnk.col_strobe_n, lnk.wr_strobe_n,
		lnk.bank_select_bits, lnk.address_lines, lnk.byte_mask_lanes, lnk.strobe_lanes,
		lnk.data_lines};
	wire s_true;
	wire s_comp;
	wire s_gate;
	wire s_cs_n;
	wire [2:0] s_cmd;
	wire [BANK_W-1:0] s_bank;
	wire [ADDR_W-1:0] s_addr;
	wire [LN-1:0] s_mask;
	wire [LN-1:0] s_stb;
	wire [DQ_W-1:0] s_dq;
	assign {s_true, s_comp, s_gate, s_cs_n, s_cmd, s_bank, s_addr, s_mask, s_stb, s_dq} = s2_ff;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			true_d_ff <= 1'b0;
			stb_d_ff <= '0;
		end
		else
		begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			true_d_ff <= s_true;
			stb_d_ff <= s_stb;
		end
	end

	// --------------------------------
	// Edges and command decode
	// --------------------------------
	mdp_pwr_t pwr_ff;
	mdp_bst_t bst_ff;
	logic [ADDR_W-1:0] mode_ff;
	logic [ADDR_W-1:0] ext_ff;
	logic [BANK_W-1:0] cur_bank_ff;
	logic [COL_W-1:0] col_base_ff;
	logic [4:0] beat_ff;
	logic [4:0] bl_ff;
	logic [2:0] lat_ff;
	logic ap_ff;
	logic [DQ_W-1:0] dq_o_ff;
	logic oe_ff;
	logic stb_o_ff;
	wire ck_rise = s_true & ~true_d_ff & ~s_comp;
	wire ck_edge = s_true ^ true_d_ff;
	wire [LN-1:0] stb_edge = s_stb ^ stb_d_ff;
	wire run = pwr_ff == PW_RUN;
	wire cmd_en = ck_rise & run & s_gate & ~s_cs_n;
	wire [2:0] cmd = s_cmd;
	wire is_act = cmd_en & (cmd == CMD_ACT);
	wire is_pre = cmd_en & (cmd == CMD_PRE);
	wire is_lmr = cmd_en & (cmd == CMD_LMR);
	wire is_bst = cmd_en & (cmd == CMD_BST);
	wire sref_req = ~s_cs_n & (cmd == CMD_AREF);
	wire bs_idle = bst_ff == BS_IDLE;
	wire [NBANK-1:0] open_w;
	wire [NBANK-1:0][ROW_W-1:0] row_w;
	wire start_rd = cmd_en & (cmd == CMD_READ) & bs_idle & open_w[s_bank];
	wire start_wr = cmd_en & (cmd == CMD_WRITE) & bs_idle & open_w[s_bank];
	wire [4:0] bl_now = mdp_bl_len(mode_ff[BL_LSB +: 3]);
	wire [2:0] cl_now = mode_ff[CL_LSB +: 3];

	// --------------------------------
	// Burst addressing
	// --------------------------------
	// Wrap within burst from start column
	wire [COL_W-1:0] bmask = COL_W'(bl_ff - 5'h01);
	wire [COL_W-1:0] col_sum = col_base_ff + COL_W'(beat_ff);
	wire [COL_W-1:0] col_eff = (col_base_ff & ~bmask) | (col_sum & bmask);
	wire [ROW_W-1:0] cur_row = row_w[cur_bank_ff];
	wire [MEM_AW-1:0] idx = {cur_bank_ff, cur_row[MEM_RB-1:0], col_eff[MEM_CB-1:0]};
	wire rd_go = (bst_ff == BS_LAT) & ck_rise & (lat_ff == 3'h1);
	wire rd_beat = rd_go | ((bst_ff == BS_RD) & ck_edge & (beat_ff != bl_ff));
	wire rd_done = (bst_ff == BS_RD) & ck_edge & (beat_ff == bl_ff);
	wire wr_beat = (bst_ff == BS_WR) & stb_edge[0];
	wire wr_done = wr_beat & (beat_ff == bl_ff - 5'h01);
	wire stop = is_bst | ~run;
	wire ap_close = (rd_done | wr_done) & ap_ff;

	// --------------------------------
	// Bank row state
	// --------------------------------
	for (genvar b = 0; b < NBANK; b++)
	begin : g_bank
		logic open_ff;
		logic [ROW_W-1:0] row_ff;
		wire sel = s_bank == BANK_W'(b);
		// Scope bit closes one or all
		wire close = (is_pre & (s_addr[PRECHARGE_SCOPE_BIT] | sel))
			| (ap_close & (cur_bank_ff == BANK_W'(b)));
		always_ff @(posedge ref_clk)
		begin
			if (srst)
			begin
				open_ff <= 1'b0;
				row_ff <= '0;
			end
			else if (is_act & sel)
			begin
				open_ff <= 1'b1;
				row_ff <= s_addr[ROW_W-1:0];
			end
			else if (close)
				open_ff <= 1'b0;
		end
		assign open_w[b] = open_ff;
		assign row_w[b] = row_ff;
	end

	// --------------------------------
	// Byte lane storage
	// --------------------------------
	wire [DQ_W-1:0] rd_word;
	for (genvar l = 0; l < LN; l++)
	begin : g_lane
		logic [BYTE_W-1:0] mem [2**MEM_AW];
		wire wr_en = (bst_ff == BS_WR) & stb_edge[l] & ~s_mask[l];
		always_ff @(posedge ref_clk)
		begin
			if (wr_en)
				mem[idx] <= s_dq[BYTE_W * l +: BYTE_W];
		end
		assign rd_word[BYTE_W * l +: BYTE_W] = mem[idx];
	end

	// --------------------------------
	// Burst engine
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bst_ff <= BS_IDLE;
			cur_bank_ff <= '0;
			col_base_ff <= '0;
			beat_ff <= '0;
			bl_ff <= '0;
			lat_ff <= '0;
			ap_ff <= 1'b0;
		end
		else if (start_rd | start_wr)
		begin
			bst_ff <= start_rd ? BS_LAT : BS_WR;
			cur_bank_ff <= s_bank;
			col_base_ff <= s_addr[COL_W-1:0];
			ap_ff <= s_addr[PRECHARGE_SCOPE_BIT];
			bl_ff <= bl_now;
			lat_ff <= cl_now;
			beat_ff <= '0;
		end
		else
		begin
			if (stop | rd_done | wr_done)
				bst_ff <= BS_IDLE;
			else if (rd_go)
				bst_ff <= BS_RD;
			if ((bst_ff == BS_LAT) & ck_rise)
				lat_ff <= lat_ff - 3'h1;
			if (rd_beat | wr_beat)
				beat_ff <= beat_ff + 5'h01;
		end
	end

	// --------------------------------
	// Read drivers
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst | stop | rd_done)
		begin
			dq_o_ff <= '0;
			oe_ff <= 1'b0;
			stb_o_ff <= 1'b0;
		end
		else if (rd_beat)
		begin
			dq_o_ff <= rd_word;
			oe_ff <= 1'b1;
			stb_o_ff <= ~stb_o_ff;
		end
	end
	assign lnk.dev_data_o = dq_o_ff;
	assign lnk.dev_data_oe = oe_ff;
	assign lnk.dev_strobe_o = {LN{stb_o_ff}};
	assign lnk.dev_strobe_oe = oe_ff;

	// --------------------------------
	// Power state
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			pwr_ff <= PW_RUN;
		else
			unique case (pwr_ff)
				PW_RUN:
					if (ck_rise & ~s_gate)
						pwr_ff <= (~|open_w & sref_req) ? PW_SREF : PW_PDN;
				PW_PDN:
					if (ck_rise & s_gate)
						pwr_ff <= PW_RUN;
				PW_SREF:
					if (s_gate)
						pwr_ff <= PW_RUN;
				default:
					pwr_ff <= PW_RUN;
			endcase
	end

	// --------------------------------
	// Mode registers
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			mode_ff <= MODE_RST;
			ext_ff <= EXT_RST;
		end
		else if (is_lmr & (s_bank == MR_BASE))
			mode_ff <= s_addr;
		else if (is_lmr & (s_bank == MR_EXT))
			ext_ff <= s_addr;
	end
	assign pwr_state = pwr_ff;
	assign open_banks = open_w;
	assign base_mode = mode_ff;
	assign ext_mode = ext_ff;
endmodule

// >>> design/mdp_host.sv
`timescale 1ns/1ns
module mdp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [CW-1:0] cnt_ff;
	logic rdy_ff;
	wire push = in_valid & rdy_ff;
	wire pop = out_ready & (cnt_ff != '0);
	wire [CW-1:0] nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
			rdy_ff <= 1'b0;
		end
		else
		begin
			wp_ff <= wp_ff + AW'(push);
			rp_ff <= rp_ff + AW'(pop);
			cnt_ff <= nxt_cnt;
			rdy_ff <= nxt_cnt != CW'(DEPTH);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wp_ff] <= in_data;
	end
	assign in_ready = rdy_ff;
	assign out_valid = cnt_ff != '0;
	assign out_data = mem[rp_ff];
endmodule

module mdp_host #(
	parameter int DQ_W = mdp_pkg::DQ_W,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic srst,
	mdp_link_if.host lnk,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire mdp_pkg::mdp_cmd_t cmd_op,
	input wire logic [mdp_pkg::BANK_W-1:0] cmd_bank,
	input wire logic [mdp_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic gate_req,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [DQ_W-1:0] wr_data,
	input wire logic [DQ_W/8-1:0] wr_mask,
	output logic rd_valid,
	output logic [DQ_W-1:0] rd_data
);
	import mdp_pkg::*;
	localparam int LN = DQ_W / BYTE_W;
	localparam int FW = DQ_W + LN;
	localparam int CW = $clog2(LINK_HALF_CYC + 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(LINK_HALF_CYC - 1);
	localparam logic [CW-1:0] PRE_TICK = CW'(LINK_HALF_CYC - 2);
	localparam logic [CW-1:0] MID = CW'(LINK_MID_CYC - 1);

	// --------------------------------
	// Link clock divider
	// --------------------------------
	logic [CW-1:0] cnt_ff;
	logic clk_ff;
	logic comp_ff;
	wire tick = cnt_ff == HALF_LAST;
	wire fall_tick = tick & clk_ff;
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cnt_ff <= '0;
			clk_ff <= 1'b0;
			comp_ff <= 1'b1;
		end
		else if (tick)
		begin
			cnt_ff <= '0;
			clk_ff <= ~clk_ff;
			comp_ff <= ~comp_ff;
		end
		else
			cnt_ff <= cnt_ff + CW'(1);
	end

	// --------------------------------
	// Command issue
	// --------------------------------
	logic cs_n_ff;
	logic [2:0] cmd_ff;
	logic [BANK_W-1:0] bank_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic gate_ff;
	logic rdy_ff;
	logic [4:0] bl_ff;
	logic [4:0] w_left_ff;
	logic [4:0] rd_left_ff;
	logic tog_ff;
	logic oe_ff;
	logic stb_ff;
	logic [DQ_W-1:0] dq_ff;
	logic [LN-1:0] mask_ff;
	logic rdv_ff;
	logic [DQ_W-1:0] rdd_ff;
	logic [DQ_W+LN-1:0] s1_ff;
	logic [DQ_W+LN-1:0] s2_ff;
	logic stb_d_ff;
	wire f_valid;
	wire [FW-1:0] f_data;
	wire busy = (w_left_ff != '0) | tog_ff | oe_ff | (rd_left_ff != '0);
	wire take = cmd_valid & rdy_ff;
	wire beat = tick & (w_left_ff != '0);
	wire is_wr = cmd_op == CMD_WRITE;
	wire s_stb = s2_ff[DQ_W];
	wire cap = (rd_left_ff != '0) & (s_stb ^ stb_d_ff);

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cs_n_ff <= 1'b1;
			cmd_ff <= CMD_NOP;
			bank_ff <= '0;
			addr_ff <= '0;
			gate_ff <= 1'b0;
			rdy_ff <= 1'b0;
		end
		else
		begin
			// Offer exactly the cycle of the falling tick
			rdy_ff <= ~busy & ~take & clk_ff & (cnt_ff == PRE_TICK) & (~is_wr | f_valid);
			if (fall_tick)
			begin
				cs_n_ff <= ~take;
				cmd_ff <= take ? cmd_op : CMD_NOP;
				bank_ff <= cmd_bank;
				addr_ff <= cmd_addr;
				gate_ff <= gate_req;
			end
		end
	end

	// --------------------------------
	// Burst bookkeeping
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			bl_ff <= mdp_bl_len(MODE_RST[BL_LSB +: 3]);
			w_left_ff <= '0;
			rd_left_ff <= '0;
		end
		else
		begin
			if (take & (cmd_op == CMD_LMR) & (cmd_bank == MR_BASE))
				bl_ff <= mdp_bl_len(cmd_addr[BL_LSB +: 3]);
			if (take & is_wr)
				w_left_ff <= bl_ff;
			else if (beat)
				w_left_ff <= w_left_ff - 5'h01;
			if (take & (cmd_op == CMD_READ))
				rd_left_ff <= bl_ff;
			else if (cap)
				rd_left_ff <= rd_left_ff - 5'h01;
		end
	end

	// --------------------------------
	// Write drive
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			dq_ff <= '0;
			mask_ff <= '0;
			oe_ff <= 1'b0;
			tog_ff <= 1'b0;
			stb_ff <= 1'b0;
		end
		else if (beat)
		begin
			dq_ff <= f_data[DQ_W-1:0];
			mask_ff <= f_valid ? f_data[FW-1:DQ_W] : '1;
			oe_ff <= 1'b1;
			tog_ff <= 1'b1;
		end
		else if ((cnt_ff == MID) & tog_ff)
		begin
			stb_ff <= ~stb_ff;
			tog_ff <= 1'b0;
		end
		else if (tick & oe_ff & (w_left_ff == '0) & ~tog_ff)
		begin
			oe_ff <= 1'b0;
			mask_ff <= '0;
		end
	end

	// --------------------------------
	// Read capture
	// --------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			stb_d_ff <= 1'b0;
			rdv_ff <= 1'b0;
			rdd_ff <= '0;
		end
		else
		begin
			s1_ff <= {lnk.strobe_lanes, lnk.data_lines};
			s2_ff <= s1_ff;
			stb_d_ff <= s_stb;
			rdv_ff <= cap;
			if (cap)
				rdd_ff <= s2_ff[DQ_W-1:0];
		end
	end

	mdp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data({wr_mask, wr_data}),
		.out_valid(f_valid),
		.out_ready(beat),
		.out_data(f_data)
	);

	assign lnk.diff_clock_true = clk_ff;
	assign lnk.diff_clock_comp = comp_ff;
	assign lnk.clock_gate = gate_ff;
	assign {lnk.row_strobe_n, lnk.col_strobe_n, lnk.wr_strobe_n} = cmd_ff;
	assign lnk.chip_sel_n = cs_n_ff;
	assign lnk.bank_select_bits = bank_ff;
	assign lnk.address_lines = addr_ff;
	assign lnk.byte_mask_lanes = mask_ff;
	assign lnk.host_data_o = dq_ff;
	assign lnk.host_data_oe = oe_ff;
	assign lnk.host_strobe_o = {LN{stb_ff}};
	assign lnk.host_strobe_oe = oe_ff;
	assign cmd_ready = rdy_ff;
	assign rd_valid = rdv_ff;
	assign rd_data = rdd_ff;
endmodule

// >>> dv/mdp_assertions.sv
`timescale 1ns/1ns
module mdp_assertions #(
	parameter int DQ_W = 16
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic diff_clock_true,
	input wire logic diff_clock_comp,
	input wire logic clock_gate,
	input wire logic chip_sel_n,
	input wire logic [mdp_pkg::ADDR_W-1:0] address_lines,
	input wire logic [DQ_W/8-1:0] byte_mask_lanes,
	input wire logic [DQ_W-1:0] host_data_o,
	input wire logic host_data_oe,
	input wire logic [DQ_W/8-1:0] host_strobe_o,
	input wire logic host_strobe_oe,
	input wire logic dev_data_oe,
	input wire logic [DQ_W/8-1:0] dev_strobe_o,
	input wire logic dev_strobe_oe
);
	import mdp_pkg::*;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ----------------
	// Link sequences
	// ----------------
	sequence half_then_fall(s);
		$stable(s) [*3] ##1 $fell(s);
	endsequence

	sequence beat_held;
		$stable({host_data_o, byte_mask_lanes}) ##1 $stable({host_data_o, byte_mask_lanes});
	endsequence

	// ----------------
	// Checks
	// ----------------
	chk_clock_period: assert property ($rose(diff_clock_true) |=> half_then_fall(diff_clock_true))
		else $error("link clock half period wrong");
	chk_comp_inverse: assert property (diff_clock_comp == !diff_clock_true)
		else $error("link clock pair not complementary");
	chk_gate_on_fall: assert property ($changed(clock_gate) |-> $fell(diff_clock_true))
		else $error("clock gate moved off a falling tick");
	chk_cmd_held: assert property ($fell(chip_sel_n) |=> $stable({chip_sel_n, address_lines}) [*7])
		else $error("command not held for a link cycle");
	chk_no_contention: assert property (!(host_data_oe && dev_data_oe))
		else $error("both ends drive the data lines");
	chk_lanes_together: assert property (dev_strobe_oe |-> dev_strobe_o == '0 || dev_strobe_o == '1)
		else $error("read strobe lanes differ");
	chk_write_centred: assert property (host_strobe_oe && $changed(host_strobe_o) |-> beat_held)
		else $error("write strobe not centred on data");
	chk_wr_strobe_rate: assert property (host_strobe_oe && $rose(host_strobe_o[0]) |=> half_then_fall(host_strobe_o[0]))
		else $error("write strobe rate wrong");
	chk_rd_strobe_rate: assert property (dev_strobe_oe && $rose(dev_strobe_o[0]) |=> half_then_fall(dev_strobe_o[0]))
		else $error("read strobe rate wrong");
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ns
module tb;
	import mdp_pkg::*;
	logic ref_clk;
	logic srst;
	logic cmd_valid;
	logic cmd_ready;
	mdp_cmd_t cmd_op;
	logic [BANK_W-1:0] cmd_bank;
	logic [ADDR_W-1:0] cmd_addr;
	logic gate_req;
	logic wr_valid;
	logic wr_ready;
	logic [DQ_W-1:0] wr_data;
	logic [1:0] wr_mask;
	logic rd_valid;
	logic [DQ_W-1:0] rd_data;
	mdp_pwr_t pwr_state;
	logic [NBANK-1:0] open_banks;
	logic [ADDR_W-1:0] base_mode;
	logic [ADDR_W-1:0] ext_mode;
	logic [DQ_W-1:0] got [16];
	logic [DQ_W-1:0] exp;
	int nrd;
	int fails;
	int num_checks;

	mdp_link_if lnk ();
	mdp_dev i_mdp_dev (.ref_clk, .srst, .lnk(lnk), .pwr_state, .open_banks, .base_mode,
		.ext_mode);
	mdp_host i_mdp_host (.ref_clk, .srst, .lnk(lnk), .cmd_valid, .cmd_ready, .cmd_op,
		.cmd_bank, .cmd_addr, .gate_req, .wr_valid, .wr_ready, .wr_data, .wr_mask,
		.rd_valid, .rd_data);
	mdp_assertions i_mdp_assertions (.ref_clk, .srst,
		.diff_clock_true(lnk.diff_clock_true), .diff_clock_comp(lnk.diff_clock_comp),
		.clock_gate(lnk.clock_gate), .chip_sel_n(lnk.chip_sel_n),
		.address_lines(lnk.address_lines), .byte_mask_lanes(lnk.byte_mask_lanes),
		.host_data_o(lnk.host_data_o), .host_data_oe(lnk.host_data_oe),
		.host_strobe_o(lnk.host_strobe_o), .host_strobe_oe(lnk.host_strobe_oe),
		.dev_data_oe(lnk.dev_data_oe), .dev_strobe_o(lnk.dev_strobe_o),
		.dev_strobe_oe(lnk.dev_strobe_oe));

	// ----------------
	// Tasks
	// ----------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic cmd(input mdp_cmd_t op, input logic [1:0] bank, input logic [13:0] addr);
		int n;
		idle(1);
		cmd_op = op;
		cmd_bank = bank;
		cmd_addr = addr;
		cmd_valid = 1'b1;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			idle(1);
			n++;
		end
		check(cmd_ready, 1'b1);
		idle(1);
		cmd_valid = 1'b0;
		idle(16);
	endtask

	task automatic push(input logic [15:0] d, input logic [1:0] m);
		int n;
		idle(1);
		wr_data = d;
		wr_mask = m;
		wr_valid = 1'b1;
		n = 0;
		while (wr_ready !== 1'b1 && n < 100)
		begin
			idle(1);
			n++;
		end
		idle(1);
		wr_valid = 1'b0;
	endtask

	task automatic rd(input logic [1:0] bank, input logic [13:0] addr);
		nrd = 0;
		cmd(CMD_READ, bank, addr);
		repeat (200)
		begin
			if (rd_valid === 1'b1 && nrd < 16)
			begin
				got[nrd] = rd_data;
				nrd++;
			end
			idle(1);
		end
	endtask

	// ----------------
	// Clock, watchdog, tests
	// ----------------
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial
	begin
		#400000;
		fails++;
		end_sim();
	end

	initial
	begin
		fails = 0;
		num_checks = 0;
		srst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = CMD_NOP;
		cmd_bank = 2'h0;
		cmd_addr = 14'h0000;
		gate_req = 1'b0;
		wr_valid = 1'b0;
		wr_data = 16'h0000;
		wr_mask = 2'h0;
		idle(16);
		srst = 1'b0;
		check(base_mode, MODE_RST);
		check(ext_mode, EXT_RST);
		check(open_banks, 4'h0);
		check(pwr_state, PW_RUN);
		check(lnk.dev_data_oe, 1'b0);
		gate_req = 1'b1;
		idle(16);
		cmd(CMD_LMR, MR_BASE, 14'h0022);
		check(base_mode, 14'h0022);
		cmd(CMD_LMR, MR_EXT, 14'h0155);
		check(ext_mode, 14'h0155);
		check(base_mode, 14'h0022);
		for (int i = 0; i < 8; i++)
			push(i < 4 ? 16'hA0B0 + 16'(i) : 16'hC0D0 + 16'(i), i < 4 ? 2'h0 : 2'(i));
		check(wr_ready, 1'b0);
		cmd(CMD_ACT, 2'h1, 14'h0002);
		check(open_banks, 4'h2);
		cmd(CMD_WRITE, 2'h1, 14'h0004);
		cmd(CMD_WRITE, 2'h1, 14'h0004);
		check(wr_ready, 1'b1);
		rd(2'h1, 14'h0004);
		check(nrd, 4);
		for (int i = 0; i < 4; i++)
		begin
			exp = {(i[1] ? 8'hA0 : 8'hC0), (i[0] ? 8'hB0 : 8'hD4) + 8'(i)};
			check(got[i], exp);
		end
		rd(2'h1, 14'h0404);
		check(open_banks, 4'h0);
		for (int c = 1; c < 5; c++)
		begin
			cmd(CMD_PRE, 2'h0, 14'h0400);
			cmd(CMD_LMR, MR_BASE, 14'h0020 | 14'(c));
			cmd(CMD_ACT, 2'h0, 14'h0000);
			rd(2'h0, 14'h0000);
			check(nrd, 1 << c);
		end
		cmd(CMD_ACT, 2'h3, 14'h0001);
		check(open_banks, 4'h9);
		cmd(CMD_PRE, 2'h3, 14'h0000);
		check(open_banks, 4'h1);
		cmd(CMD_PRE, 2'h2, 14'h0400);
		check(open_banks, 4'h0);
		cmd(CMD_ACT, 2'h2, 14'h0003);
		gate_req = 1'b0;
		idle(40);
		check(pwr_state, PW_PDN);
		gate_req = 1'b1;
		idle(40);
		check(pwr_state, PW_RUN);
		check(open_banks, 4'h4);
		// --------------------------------
		// Self refresh entry and exit
		// --------------------------------
		cmd(CMD_PRE, 2'h0, 14'h0400);
		check(open_banks, 4'h0);
		gate_req = 1'b0;
		cmd(CMD_AREF, 2'h0, 14'h0000);
		check(pwr_state, PW_SREF);
		gate_req = 1'b1;
		idle(40);
		check(pwr_state, PW_RUN);
		end_sim();
	end
endmodule
